// ### logic/uart_modem_status_divisor_regs.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "uart_regs_map.svh"
module uart_modem_status_divisor_regs
   import uart_regs_pkg::*;
#(
   // Identification word; the value is arbitrary.
   parameter logic [31:0] IDENT_WORD = 32'h0000_5A5A
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Register port
   input  wire reg_req_t    req,
   output logic [31:0]      rdata,
   // Receive and transmit data of the surrounding UART
   input  wire logic [7:0]  rx_data,
   output logic             rx_read,
   output logic [7:0]       tx_data,
   output logic             tx_load,
   // Modem lines
   input  wire modem_in_t   modem,
   output logic             term_ready_n,
   output logic             send_req_n,
   // Control towards the rest of the UART
   output logic [7:0]       line_control,
   output logic [7:0]       int_enable,
   output logic [15:0]      divisor,
   output logic             baud_tick,
   output logic             reload_busy,
   output logic             modem_irq
);

   state_t st_q;
   state_t st_d;

   function automatic logic [31:0] word8(input logic [7:0] b);
      word8 = {24'h00_0000, b};
   endfunction

   function automatic logic [15:0] div_word(input logic [7:0] hi,
                                            input logic [7:0] lo);
      div_word = {hi, lo};
   endfunction

   logic       divisor_access_select;
   logic       loop;
   logic [3:0] stat_now;
   logic [3:0] ev;
   logic       rd_stat;
   logic       div_wr;
   logic [15:0] div_now;

   assign divisor_access_select    = st_q.line_control_reg[`LC_DIV_SEL];
   assign loop    = st_q.modem_control_reg[`MC_LOOP];
   assign rd_stat = req.rd && (req.addr == `OFS_MODEM_STAT);
   assign div_now = div_word(st_q.div_hi, st_q.div_lo);

   // Upper status nibble: inverted pins, or the control bits in loopback.
   always_comb begin
      if (loop) begin
         stat_now[`ST_CD] = st_q.modem_control_reg[`MC_USER_USER_OUTPUT_SECOND]; // [RULE_02]
         stat_now[`ST_RI] = st_q.modem_control_reg[`MC_USER_USER_OUTPUT_FIRST]; // [RULE_03]
         stat_now[`ST_SR] = st_q.modem_control_reg[`MC_TERM_READY]; // [RULE_04]
         stat_now[`ST_CS] = st_q.modem_control_reg[`MC_SEND_REQ]; // [RULE_05]
      end else begin
         stat_now[`ST_CD] = ~modem.dcd_n; // [RULE_02]
         stat_now[`ST_RI] = ~modem.ri_n; // [RULE_03]
         stat_now[`ST_SR] = ~modem.dsr_n; // [RULE_04]
         stat_now[`ST_CS] = ~modem.cts_n; // [RULE_05]
      end
   end

   // Change events against the value seen one cycle earlier.
   always_comb begin
      ev[`FL_CD] = stat_now[`ST_CD] ^ st_q.prev[`ST_CD]; // [RULE_06]
      // Ring pin rising means the inverted bit falls.
      ev[`FL_RI] = st_q.prev[`ST_RI] & ~stat_now[`ST_RI]; // [RULE_07]
      ev[`FL_SR] = stat_now[`ST_SR] ^ st_q.prev[`ST_SR]; // [RULE_08]
      ev[`FL_CS] = stat_now[`ST_CS] ^ st_q.prev[`ST_CS]; // [RULE_10]
   end

   assign div_wr = req.wr && ((req.addr == `OFS_DIV_LOW) ||
                              (req.addr == `OFS_DIV_HIGH) ||
                              (divisor_access_select && (req.addr == `OFS_SHARED_LOW)) ||
                              (divisor_access_select && (req.addr == `OFS_SHARED_HIGH)));

   always_comb begin
      st_d = st_q;
      st_d.tx_load = 1'b0;
      st_d.rx_read = 1'b0;
      st_d.rdata = 32'h0000_0000;
      st_d.prev = stat_now;

      // A read clears the flags, but an event in the same cycle still sets.
      if (rd_stat) begin
         st_d.flags = ev; // [RULE_20]
      end else begin
         st_d.flags = st_q.flags | ev; // [RULE_06] [RULE_07] [RULE_08]
      end

      if (req.wr) begin
         case (req.addr)
            `OFS_SHARED_LOW: begin
               if (divisor_access_select) begin
                  st_d.div_lo = req.wdata[7:0]; // [RULE_15]
               end else begin
                  st_d.tx_data = req.wdata[7:0]; // [RULE_15]
                  st_d.tx_load = 1'b1;
               end
            end
            `OFS_SHARED_HIGH: begin
               if (divisor_access_select) begin
                  st_d.div_hi = req.wdata[7:0]; // [RULE_16]
               end else begin
                  st_d.interrupt_enable_reg = req.wdata[7:0]; // [RULE_16]
               end
            end
            `OFS_LINE_CTRL: begin
               st_d.line_control_reg = req.wdata[7:0];
            end
            `OFS_MODEM_CTRL: begin
               st_d.modem_control_reg = req.wdata[7:0];
            end
            `OFS_SCRATCH: begin
               st_d.scratch_byte = req.wdata[7:0]; // [RULE_11]
            end
            `OFS_DIV_LOW: begin
               st_d.div_lo = req.wdata[7:0]; // [RULE_17]
            end
            `OFS_DIV_HIGH: begin
               st_d.div_hi = req.wdata[7:0]; // [RULE_17]
            end
            // Status and identification words take no writes.
            default: begin
               st_d.rdata = 32'h0000_0000; // [RULE_01]
            end
         endcase
      end

      if (req.rd) begin
         case (req.addr)
            `OFS_SHARED_LOW: begin
               if (divisor_access_select) begin
                  st_d.rdata = word8(st_q.div_lo); // [RULE_15]
               end else begin
                  st_d.rdata = word8(rx_data); // [RULE_15]
                  st_d.rx_read = 1'b1;
               end
            end
            `OFS_SHARED_HIGH: begin
               st_d.rdata = word8(divisor_access_select ? st_q.div_hi : st_q.interrupt_enable_reg); // [RULE_16]
            end
            `OFS_LINE_CTRL: begin
               st_d.rdata = word8(st_q.line_control_reg);
            end
            `OFS_MODEM_CTRL: begin
               st_d.rdata = word8(st_q.modem_control_reg);
            end
            `OFS_MODEM_STAT: begin
               st_d.rdata = word8({stat_now, st_q.flags | ev});
            end
            `OFS_SCRATCH: begin
               st_d.rdata = word8(st_q.scratch_byte); // [RULE_11]
            end
            `OFS_DIV_LOW: begin
               st_d.rdata = word8(st_q.div_lo); // [RULE_17]
            end
            `OFS_DIV_HIGH: begin
               st_d.rdata = word8(st_q.div_hi); // [RULE_17]
            end
            `OFS_IDENT_WORD: begin
               st_d.rdata = IDENT_WORD; // [RULE_19]
            end
            `OFS_IDENT_BYTE: begin
               st_d.rdata = word8(`IDENT_BYTE_VAL); // [RULE_19]
            end
            default: begin
               st_d.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Interrupt from the registered flags; the send flag is muted by autoflow.
      st_d.irq = st_q.interrupt_enable_reg[`IE_MODEM] &
                 (st_q.flags[`FL_CD] | st_q.flags[`FL_RI] |
                  st_q.flags[`FL_SR] |
                  (st_q.flags[`FL_CS] & ~st_q.modem_control_reg[`MC_AUTOFLOW])); // [RULE_09] [RULE_10]

      // The generator is held for two cycles while the new divisor loads.
      st_d.baud_tick = 1'b0;
      if (div_wr) begin
         st_d.reload = `RELOAD_WAITS; // [RULE_13]
      end else if (st_q.reload != 2'h0) begin
         st_d.reload = st_q.reload - 2'h1; // [RULE_13]
         st_d.baud_cnt = div_now - `DIV_ONE; // [RULE_12]
      end else if (div_now != 16'h0000) begin
         if (st_q.baud_cnt == 16'h0000) begin
            st_d.baud_cnt = div_now - `DIV_ONE; // [RULE_12]
            st_d.baud_tick = 1'b1;
         end else begin
            st_d.baud_cnt = st_q.baud_cnt - `DIV_ONE;
         end
      end

      // Pin-facing and busy outputs are registered copies of the next state.
      st_d.busy   = (st_d.reload != 2'h0); // [RULE_13]
      st_d.term_n = ~st_d.modem_control_reg[`MC_TERM_READY];
      st_d.send_n = ~st_d.modem_control_reg[`MC_SEND_REQ];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q.line_control_reg       <= `BYTE_RST;
         st_q.modem_control_reg       <= `BYTE_RST;
         st_q.interrupt_enable_reg       <= `BYTE_RST;
         st_q.scratch_byte       <= `BYTE_RST;
         st_q.div_lo    <= `BYTE_RST;
         st_q.div_hi    <= `BYTE_RST;
         st_q.prev      <= 4'h0;
         st_q.flags     <= 4'h0;
         st_q.rdata     <= 32'h0000_0000;
         st_q.tx_data   <= `BYTE_RST;
         st_q.tx_load   <= 1'b0;
         st_q.rx_read   <= 1'b0;
         st_q.irq       <= 1'b0;
         st_q.reload    <= 2'h0;
         st_q.baud_cnt  <= 16'h0000;
         st_q.baud_tick <= 1'b0;
         st_q.busy      <= 1'b0;
         st_q.term_n    <= 1'b1;
         st_q.send_n    <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata        = st_q.rdata;
   assign rx_read      = st_q.rx_read;
   assign tx_data      = st_q.tx_data;
   assign tx_load      = st_q.tx_load;
   assign term_ready_n = st_q.term_n;
   assign send_req_n   = st_q.send_n;
   assign line_control = st_q.line_control_reg;
   assign int_enable   = st_q.interrupt_enable_reg;
   assign divisor      = div_word(st_q.div_hi, st_q.div_lo); // [RULE_12]
   assign baud_tick    = st_q.baud_tick;
   assign reload_busy  = st_q.busy;
   assign modem_irq    = st_q.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   cd_loop_a: assert property ( // [RULE_02]
      (rd_stat && loop) |=> rdata[7] == $past(st_q.modem_control_reg[`MC_USER_USER_OUTPUT_SECOND]))
      else $error("Carrier bit does not follow user output two in loopback.");

   ri_loop_a: assert property ( // [RULE_03]
      (rd_stat && loop) |=> rdata[6] == $past(st_q.modem_control_reg[`MC_USER_USER_OUTPUT_FIRST]))
      else $error("Ring bit does not follow user output one in loopback.");

   sr_pin_a: assert property ( // [RULE_04]
      (rd_stat && !loop) |=> rdata[5] == $past(~modem.dsr_n))
      else $error("Set ready bit is not the inverted pin.");

   cs_pin_a: assert property ( // [RULE_05]
      (rd_stat && !loop) |=> rdata[4] == $past(~modem.cts_n))
      else $error("Clear to send bit is not the inverted pin.");

   cd_change_a: assert property ( // [RULE_06]
      (stat_now[`ST_CD] != st_q.prev[`ST_CD]) |=> st_q.flags[`FL_CD])
      else $error("Carrier change did not set its flag.");

   ring_edge_a: assert property ( // [RULE_07]
      (!loop && $rose(modem.ri_n) && !$past(loop)) |=> st_q.flags[`FL_RI])
      else $error("Ring rising edge did not set its flag.");

   sr_change_a: assert property ( // [RULE_08]
      (!loop && $changed(modem.dsr_n) && !$past(loop)) |=> st_q.flags[`FL_SR])
      else $error("Set ready change did not set its flag.");

   irq_cause_a: assert property ( // [RULE_09]
      (st_q.interrupt_enable_reg[`IE_MODEM] && (st_q.flags[3:1] != 3'h0)) |=> modem_irq)
      else $error("Modem interrupt missing for a set flag.");

   autoflow_mute_a: assert property ( // [RULE_10]
      (st_q.modem_control_reg[`MC_AUTOFLOW] && st_q.flags[3:1] == 3'h0) |=> !modem_irq)
      else $error("Send change raised an interrupt under autoflow.");

   scratch_back_a: assert property ( // [RULE_11]
      (req.wr && req.addr == `OFS_SCRATCH) ##1
      (req.rd && req.addr == `OFS_SCRATCH && !req.wr)
      |=> rdata == word8($past(req.wdata[7:0], 2)))
      else $error("Scratch byte did not read back.");

   div_high_a: assert property ( // [RULE_12]
      (req.wr && req.addr == `OFS_DIV_HIGH)
      |=> divisor[15:8] == $past(req.wdata[7:0]) && $stable(divisor[7:0]))
      else $error("High divisor latch not in the upper byte.");

   reload_two_a: assert property ( // [RULE_13]
      (div_wr && !reload_busy) |=> reload_busy [*2] ##1
      (reload_busy == ($past(div_wr) || $past(div_wr, 2))))
      else $error("Baud reload did not hold for two cycles.");

   shared_low_a: assert property ( // [RULE_15]
      (req.wr && req.addr == `OFS_SHARED_LOW && !divisor_access_select)
      |=> tx_load && $stable(divisor))
      else $error("Shared low write reached the wrong register.");

   shared_high_a: assert property ( // [RULE_16]
      (req.wr && req.addr == `OFS_SHARED_HIGH && divisor_access_select) |=> $stable(int_enable))
      else $error("Shared high write changed the enables while selected.");

   ident_word_a: assert property ( // [RULE_19]
      (req.rd && req.addr == `OFS_IDENT_WORD) |=> rdata == IDENT_WORD)
      else $error("Identification word read wrong.");

   read_clear_a: assert property ( // [RULE_20]
      (rd_stat && ev == 4'h0) |=> st_q.flags == 4'h0)
      else $error("Status read did not clear the change flags.");

   cd_pin_a: assert property ( // [RULE_02]
      (rd_stat && !loop) |=> rdata[7] == $past(~modem.dcd_n))
      else $error("Carrier bit is not the inverted pin.");

   ri_pin_a: assert property ( // [RULE_03]
      (rd_stat && !loop) |=> rdata[6] == $past(~modem.ri_n))
      else $error("Ring bit is not the inverted pin.");

   sr_loop_a: assert property ( // [RULE_04]
      (rd_stat && loop) |=> rdata[5] == $past(st_q.modem_control_reg[`MC_TERM_READY]))
      else $error("Set ready bit does not follow terminal ready in loopback.");

   cs_loop_a: assert property ( // [RULE_05]
      (rd_stat && loop) |=> rdata[4] == $past(st_q.modem_control_reg[`MC_SEND_REQ]))
      else $error("Clear to send bit does not follow send request in loopback.");

   cd_hold_a: assert property ( // [RULE_06]
      (!rd_stat && st_q.flags[`FL_CD]) |=> st_q.flags[`FL_CD])
      else $error("Carrier change flag dropped without a status read.");

   cs_change_a: assert property ( // [RULE_10]
      (stat_now[`ST_CS] != st_q.prev[`ST_CS]) |=> st_q.flags[`FL_CS])
      else $error("Send change did not set its flag.");

   scratch_alone_a: assert property ( // [RULE_11]
      (req.wr && req.addr == `OFS_SCRATCH)
      |=> $stable(divisor) && $stable(line_control) && $stable(int_enable) && !tx_load)
      else $error("Scratch write disturbed another register.");

   zero_div_a: assert property ( // [RULE_12]
      (divisor == 16'h0000) |=> !baud_tick)
      else $error("Baud tick with a zero divisor.");

   reload_quiet_a: assert property ( // [RULE_13]
      reload_busy |=> !baud_tick)
      else $error("Baud tick while the divisor reloads.");

   rx_pulse_a: assert property ( // [RULE_15]
      (req.rd && req.addr == `OFS_SHARED_LOW && !divisor_access_select)
      |=> rx_read && rdata == word8($past(rx_data)))
      else $error("Shared low read did not return the receive byte.");

   low_dedicated_a: assert property ( // [RULE_17]
      (req.wr && req.addr == `OFS_DIV_LOW)
      |=> divisor[7:0] == $past(req.wdata[7:0]) && $stable(divisor[15:8]))
      else $error("Dedicated low latch not in the lower byte.");

   ident_byte_a: assert property ( // [RULE_19]
      (req.rd && req.addr == `OFS_IDENT_BYTE) |=> rdata == word8(`IDENT_BYTE_VAL))
      else $error("Identification byte read wrong.");

   ident_ro_a: assert property ( // [RULE_19]
      (req.wr && (req.addr == `OFS_IDENT_WORD || req.addr == `OFS_IDENT_BYTE))
      |=> $stable(st_q.line_control_reg) && $stable(st_q.modem_control_reg) && $stable(st_q.scratch_byte) && $stable(divisor))
      else $error("Write to an identification register changed state.");

endmodule // uart_modem_status_divisor_regs
`default_nettype wire

// ### logic/uart_regs_map.svh
// Functional notes
// RULE_01: Software never writes the modem status register; such writes are ignored.
// RULE_02: Status bit 7 is inverted carrier detect, or user output two in loopback.
// RULE_03: Status bit 6 is inverted ring indicator, or user output one in loopback.
// RULE_04: Status bit 5 is inverted data set ready, or terminal ready in loopback.
// RULE_05: Status bit 4 is inverted clear to send, or send request in loopback.
// RULE_06: Status bit 3 sets when carrier detect changed since the last status read.
// RULE_07: Status bit 2 sets when the ring indicator input goes low to high.
// RULE_08: Status bit 1 sets when data set ready changed since the last status read.
// RULE_09: Enabled modem interrupt fires on carrier, ring or set-ready flags.
// RULE_10: Bit 0 flags clear-to-send change; interrupts only without autoflow.
// RULE_11: Eight-bit scratch field holds software data and affects nothing else.
// RULE_12: Baud divisor is high latch over low latch, sixteen bits.
// RULE_13: A divisor write reloads the baud generator over two wait cycles.
// RULE_14: Software programs both divisor latches during initialisation.
// RULE_15: Shared low address reaches divisor low when select is set, else data.
// RULE_16: Shared high address reaches divisor high when select is set, else enables.
// RULE_17: Both divisor latches also sit at dedicated addresses.
// RULE_18: Software keeps the bit rate at or below 128 kbps.
// RULE_19: Two read-only identification registers, a word and a byte.
// RULE_20: Reading modem status clears the four change flags.
`ifndef UART_REGS_MAP_SVH
`define UART_REGS_MAP_SVH
`define ADDR_W          6
`define OFS_SHARED_LOW  6'h00
`define OFS_SHARED_HIGH 6'h04
`define OFS_LINE_CTRL   6'h0C
`define OFS_MODEM_CTRL  6'h10
`define OFS_MODEM_STAT  6'h18
`define OFS_SCRATCH     6'h1C
`define OFS_DIV_LOW     6'h20
`define OFS_DIV_HIGH    6'h24
`define OFS_IDENT_WORD  6'h28
`define OFS_IDENT_BYTE  6'h2C
`define LC_DIV_SEL      7
`define MC_TERM_READY   0
`define MC_SEND_REQ     1
`define MC_USER_USER_OUTPUT_FIRST    2
`define MC_USER_USER_OUTPUT_SECOND    3
`define MC_LOOP         4
`define MC_AUTOFLOW     5
`define IE_MODEM        3
`define ST_CD           3
`define ST_RI           2
`define ST_SR           1
`define ST_CS           0
`define FL_CD           3
`define FL_RI           2
`define FL_SR           1
`define FL_CS           0
`define RELOAD_WAITS    2'h2
`define BYTE_RST        8'h00
`define IDENT_BYTE_VAL  8'h00
`define DIV_ONE         16'h0001
`endif

// ### logic/uart_regs_pkg.sv
`include "uart_regs_map.svh"
package uart_regs_pkg;
   typedef struct packed {
      logic [`ADDR_W-1:0] addr;
      logic [31:0]        wdata;
      logic               wr;
      logic               rd;
   } reg_req_t;
   typedef struct packed {
      logic dcd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } modem_in_t;
   typedef struct packed {
      logic [7:0]  line_control_reg;
      logic [7:0]  modem_control_reg;
      logic [7:0]  interrupt_enable_reg;
      logic [7:0]  scratch_byte;
      logic [7:0]  div_lo;
      logic [7:0]  div_hi;
      logic [3:0]  prev;
      logic [3:0]  flags;
      logic [31:0] rdata;
      logic [7:0]  tx_data;
      logic        tx_load;
      logic        rx_read;
      logic        irq;
      logic [1:0]  reload;
      logic [15:0] baud_cnt;
      logic        baud_tick;
      logic        busy;
      logic        term_n;
      logic        send_n;
   } state_t;
endpackage

// ### verification/modem_model.sv
`timescale 1ns/1ns
`default_nettype none
module modem_model
   import uart_regs_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Requested pin levels and pace
   input  wire logic [3:0] want,
   input  wire logic       slow,
   // Pins towards the UART
   output var  modem_in_t  lines
);
   logic [1:0] wait_q;
   // A slow data set lets a requested level wait a few cycles before it reaches the pins.
   always_ff @(posedge clk) begin
      if (reset) begin
         lines  <= 4'hF;
         wait_q <= 2'h0;
      end else if (want != lines) begin
         wait_q <= wait_q + 2'h1;
         if (!slow || wait_q == 2'h3) begin
            lines  <= want;
            wait_q <= 2'h0;
         end
      end
   end
endmodule // modem_model
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "uart_regs_map.svh"
`define CHK(nm, got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb
   import uart_regs_pkg::*;
;
   // The identification value is arbitrary.
   localparam logic [31:0] IDENT = 32'h0000_C3A5;
   logic        clk, reset, rx_read, tx_load, term_ready_n, send_req_n;
   logic        baud_tick, reload_busy, modem_irq, slow;
   reg_req_t    req;
   modem_in_t   modem;
   logic [31:0] rdata;
   logic [7:0]  rx_data, tx_data, line_control, int_enable;
   logic [15:0] divisor;
   logic [3:0]  want;
   int          fails, cmp_count;

   uart_modem_status_divisor_regs #(.IDENT_WORD(IDENT)) u_dut (
      .clk(clk), .reset(reset), .req(req), .rdata(rdata), .rx_data(rx_data),
      .rx_read(rx_read), .tx_data(tx_data), .tx_load(tx_load), .modem(modem),
      .term_ready_n(term_ready_n), .send_req_n(send_req_n), .line_control(line_control),
      .int_enable(int_enable), .divisor(divisor), .baud_tick(baud_tick),
      .reload_busy(reload_busy), .modem_irq(modem_irq));
   modem_model u_modem (.clk(clk), .reset(reset), .want(want), .slow(slow), .lines(modem));

   function automatic logic [3:0] flags(input logic [3:0] o, input logic [3:0] n);
      return ((o ^ n) & 4'hB) | (~o & n & 4'h4);
   endfunction
   function automatic logic exp_irq(input logic [3:0] o, n, input logic ie, af);
      return ie & |(flags(o, n) & {3'h7, ~af});
   endfunction

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      req.addr  <= a;
      req.wdata <= {24'h000000, d};
      req.wr    <= 1'b1;
      @(posedge clk);
      req.wr    <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge clk);
      req.rd   <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk_rd(input logic [5:0] a, input logic [31:0] e, input string nm);
      logic [31:0] d;
      rd_reg(a, d);
      `CHK(nm, d, e)
   endtask
   task automatic wr_div(input logic [5:0] a, input logic [7:0] d);
      wr_reg(a, d);
      `CHK("tx_load", tx_load, 1'b0)
      `CHK("busy first", reload_busy, 1'b1)
      @(posedge clk);
      #1 `CHK("busy second", reload_busy, 1'b1)
      @(posedge clk);
      #1 `CHK("busy end", reload_busy, 1'b0)
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      give_verdict;
   end
   initial begin
      logic [31:0] d;
      logic [7:0]  a, b, m;
      logic [3:0]  old;
      int          n;
      req = '0;
      reset = 1'b1;
      rx_data = 8'h00;
      want = 4'hF;
      slow = 1'b0;
      fails = 0;
      cmp_count = 0;
      void'($urandom(83243));
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      #1 `CHK("term ready", term_ready_n, 1'b1)
      chk_rd(`OFS_SCRATCH, 32'h0, "scratch reset");
      wr_reg(`OFS_IDENT_WORD, 8'hFF);
      chk_rd(`OFS_IDENT_WORD, IDENT, "ident word");
      wr_reg(`OFS_IDENT_BYTE, 8'hFF);
      chk_rd(`OFS_IDENT_BYTE, {24'h0, `IDENT_BYTE_VAL}, "ident byte");
      wr_reg(6'h3C, 8'hFF);
      chk_rd(6'h3C, 32'h0, "unmapped");
      for (int i = 0; i < 6; i++) begin
         a = 8'($urandom);
         wr_reg(`OFS_SCRATCH, a);
         chk_rd(`OFS_SCRATCH, {24'h0, a}, "scratch");
      end
      // Write and read back with no gap between the strobes.
      a = 8'($urandom);
      @(posedge clk);
      req.addr  <= `OFS_SCRATCH;
      req.wdata <= {24'h000000, a};
      req.wr    <= 1'b1;
      @(posedge clk);
      req.wr    <= 1'b0;
      req.rd    <= 1'b1;
      @(posedge clk);
      req.rd    <= 1'b0;
      #1 `CHK("scratch back to back", rdata, {24'h0, a})
      `CHK("divisor untouched", divisor, 16'h0)
      for (int i = 0; i < 4; i++) begin
         a = 8'($urandom);
         // A nonzero high latch keeps the bit rate far below its ceiling.
         b = 8'($urandom) | 8'h01;
         wr_reg(`OFS_LINE_CTRL, i[0] ? 8'h00 : 8'h80);
         `CHK("line control", line_control, i[0] ? 8'h00 : 8'h80)
         wr_div(i[0] ? `OFS_DIV_LOW : `OFS_SHARED_LOW, a);
         wr_div(i[0] ? `OFS_DIV_HIGH : `OFS_SHARED_HIGH, b);
         `CHK("divisor", divisor, {b, a})
         chk_rd(i[0] ? `OFS_DIV_LOW : `OFS_SHARED_LOW, {24'h0, a}, "div low");
         chk_rd(i[0] ? `OFS_DIV_HIGH : `OFS_SHARED_HIGH, {24'h0, b}, "div high");
         `CHK("enable kept", int_enable, 8'h00)
      end
      m = a;
      a = 8'($urandom);
      wr_reg(`OFS_SHARED_LOW, a);
      `CHK("tx_load", tx_load, 1'b1)
      `CHK("tx_data", tx_data, a)
      wr_reg(`OFS_SHARED_HIGH, 8'h08);
      `CHK("int enable", int_enable, 8'h08)
      `CHK("divisor kept", divisor, {b, m})
      m = 8'($urandom);
      rx_data <= m;
      chk_rd(`OFS_SHARED_LOW, {24'h0, m}, "rx data");
      `CHK("rx_read", rx_read, 1'b1)
      rd_reg(`OFS_MODEM_STAT, d);
      for (int i = 0; i < 16; i++) begin
         m = 8'($urandom) & 8'h2F;
         wr_reg(`OFS_MODEM_CTRL, m);
         `CHK("term ready", term_ready_n, ~m[0])
         `CHK("send request", send_req_n, ~m[1])
         wr_reg(`OFS_SHARED_HIGH, {4'h0, i[2], 3'h0});
         old = modem;
         want <= 4'($urandom);
         slow <= i[1];
         repeat (10) @(posedge clk);
         #1 `CHK("irq", modem_irq, exp_irq(old, want, i[2], m[5]))
         chk_rd(`OFS_MODEM_STAT, {24'h0, ~want, flags(old, want)}, "status");
         chk_rd(`OFS_MODEM_STAT, {24'h0, ~want, 4'h0}, "status cleared");
         `CHK("irq cleared", modem_irq, 1'b0)
      end
      for (int i = 0; i < 4; i++) begin
         m = 8'h10 | (8'($urandom) & 8'h0F);
         wr_reg(`OFS_MODEM_CTRL, m);
         rd_reg(`OFS_MODEM_STAT, d);
         `CHK("loop status", d[7:4], {m[3], m[2], m[0], m[1]})
      end
      wr_reg(`OFS_MODEM_CTRL, 8'h00);
      // A divisor of 64 keeps the bit rate under its ceiling; ten periods give ten ticks.
      wr_div(`OFS_DIV_HIGH, 8'h00);
      wr_div(`OFS_DIV_LOW, 8'h40);
      n = 0;
      repeat (640) begin
         @(posedge clk);
         #1 n += baud_tick;
      end
      `CHK("baud ticks", n, 10)
      give_verdict;
   end
endmodule // tb
`default_nettype wire
